// >>> src/smr_map.svh
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH
`define SMR_A_CMD       8'h00
`define SMR_A_STAT      8'h04
`define SMR_A_H2D_BASE  8'h08
`define SMR_A_H2D_HEAD  8'h0C
`define SMR_A_D2H_BASE  8'h10
`define SMR_A_D2H_HEAD  8'h14
`define SMR_A_GEOM      8'h18
`define SMR_A_LEN       8'h1C
`define SMR_A_NTF_TYPE  8'h20
`define SMR_A_NTF_VAL   8'h24
`define SMR_A_NTF_ADDR  8'h28
`define SMR_A_DATA      8'h40
`define SMR_CMD_INIT_H2D 3'h1
`define SMR_CMD_INIT_D2H 3'h2
`define SMR_CMD_SEND     3'h3
`define SMR_CMD_RECV     3'h4
`define SMR_NTF_NONE    3'h0
`define SMR_NTF_MMAP    3'h2
`define SMR_NTF_VECT    3'h4
`define SMR_F_LINK_HI   16'h0001
`define SMR_F_RSVD      16'h0002
`define SMR_F_STAT      16'h0003
`define SMR_F_LEN       16'h0004
`define SMR_F_LEN_HI    16'h0005
`define SMR_F_DATA      16'h0006
`define SMR_ST_OWN      0
`define SMR_ST_DONE     1
`define SMR_ST_OVF      2
`define SMR_ST_H2D_INIT 8'h02
`define SMR_ST_D2H_INIT 8'h03
`define SMR_ST_GIVE     8'h01
`define SMR_ST_RETURN   8'h03
`define SMR_STAT_NOTE   3
`define SMR_RST_PAY     16'h0020
`define SMR_RST_CNT     8'h03
`define SMR_RSVD_VAL    8'h00
`endif

// >>> src/smr_pkg.sv
package smr_pkg;
    typedef enum logic [2:0] {
        SMR_IDLE, SMR_INIT, SMR_CHK, SMR_LINK, SMR_XFER, SMR_RET, SMR_NOTE
    } smr_state_e;
    typedef enum logic [1:0] {SMR_OP_INIT, SMR_OP_SEND, SMR_OP_RECV} smr_op_e;
    typedef struct packed {
        logic        valid;
        logic        we;
        logic [5:0]  am;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } smr_mem_req_s;
    typedef struct packed {
        logic        ready;
        logic [7:0]  rdata;
    } smr_mem_rsp_s;
    typedef struct packed {
        logic        valid;
        logic [5:0]  am;
        logic [23:0] addr;
        logic [15:0] data;
    } smr_bus_wr_s;
    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
    } smr_vec_irq_s;
endpackage

// >>> src/smr_host.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "smr_map.svh"
module smr_host #(
    parameter int DATA_BYTES = 16
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 arst_n_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [7:0]           paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    output smr_pkg::smr_mem_req_s     mem_req_out,
    input  wire smr_pkg::smr_mem_rsp_s mem_rsp_in,
    input  wire smr_pkg::smr_bus_wr_s  snoop_in,
    input  wire smr_pkg::smr_vec_irq_s vec_irq_in,
    output logic                      notify_out
);
    import smr_pkg::*;
    localparam int IW = $clog2(DATA_BYTES);

    smr_state_e  state_q, state_d;
    smr_op_e     op_q, op_d;
    logic        sel_q, sel_d;
    logic [31:0] h2d_base_q, h2d_base_d, d2h_base_q, d2h_base_d, ntf_addr_q, ntf_addr_d;
    logic [15:0] h2d_head_q, h2d_head_d, d2h_head_q, d2h_head_d;
    logic [15:0] pay_q, pay_d, len_q, len_d, ntf_val_q, ntf_val_d;
    logic [15:0] cur_q, cur_d, k_q, k_d, lnk_lo_q, lnk_lo_d;
    logic [7:0]  cnt_q, cnt_d, n_q, n_d, st_q, st_d;
    logic [2:0]  ntf_type_q, ntf_type_d;
    logic        empty_q, empty_d, ovf_q, ovf_d, done_q, done_d, note_q, note_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  data_q [DATA_BYTES];
    logic [7:0]  data_d [DATA_BYTES];

    logic        wr, rd_setup, hit, acc, in_data, last_xfer;
    logic [31:0] base_s;
    logic [15:0] head_s, off, link, lmt, lmt_now, idx;
    logic [IW-1:0] di;

    // Offset adds onto the full 24-bit base, so a segment may straddle a 64K line
    function automatic logic [23:0] phys(input logic [31:0] b, input logic [15:0] o);
        return b[23:0] + {8'h00, o};
    endfunction

    function automatic logic [15:0] lim(input logic [15:0] l);
        return (l > 16'(DATA_BYTES)) ? 16'(DATA_BYTES) : l;
    endfunction

    assign wr       = psel_in & penable_in & pwrite_in;
    assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
    assign in_data  = (paddr_in >= `SMR_A_DATA) && (paddr_in < `SMR_A_DATA + 8'(DATA_BYTES));
    assign base_s   = sel_q ? d2h_base_q : h2d_base_q;
    assign head_s   = sel_q ? d2h_head_q : h2d_head_q;
    assign acc      = mem_req_out.valid & mem_rsp_in.ready;
    assign idx      = k_q - `SMR_F_RSVD;
    assign di       = idx[IW-1:0];
    assign lmt      = lim(len_q);
    assign lmt_now  = (op_q == SMR_OP_RECV && k_q == `SMR_F_LINK_HI)
                    ? lim({mem_rsp_in.rdata, len_q[7:0]}) : lmt;
    assign last_xfer = (k_q + 16'h0001) >= (lmt_now + `SMR_F_RSVD);
    // Last buffer closes the circle back to the first
    assign link     = ((n_q + 8'h01) >= cnt_q) ? head_s
                    : cur_q + `SMR_F_DATA + pay_q;

    // Notice decode; reserved codes decode to nothing
    always_comb begin
        unique case (ntf_type_q)
            `SMR_NTF_MMAP: hit = snoop_in.valid
                               && snoop_in.addr == ntf_addr_q[23:0]
                               && snoop_in.am == ntf_addr_q[29:24]
                               && snoop_in.data == ntf_val_q;
            `SMR_NTF_VECT: hit = vec_irq_in.valid
                               && vec_irq_in.vector == ntf_addr_q[31:16];
            default:       hit = 1'b0;
        endcase
    end

    always_comb begin
        mem_req_out       = '0;
        mem_req_out.am    = base_s[29:24];
        off               = cur_q;
        unique case (state_q)
            SMR_INIT: off = cur_q + k_q;
            SMR_CHK:  off = cur_q + `SMR_F_STAT;
            SMR_LINK: off = cur_q + k_q;
            SMR_XFER: off = cur_q + `SMR_F_LEN + k_q;
            SMR_RET:  off = (k_q == `SMR_F_RSVD) ? cur_q + `SMR_F_STAT : cur_q + `SMR_F_LEN + k_q;
            default:  off = cur_q;
        endcase
        mem_req_out.addr  = phys(base_s, off);
        mem_req_out.valid = state_q inside {SMR_INIT, SMR_CHK, SMR_LINK, SMR_XFER, SMR_RET};
        mem_req_out.we    = state_q inside {SMR_INIT, SMR_RET}
                          || (state_q == SMR_XFER && op_q == SMR_OP_SEND);
        unique case (state_q)
            SMR_INIT: begin
                unique case (k_q)
                    16'h0000:      mem_req_out.wdata = link[7:0];
                    `SMR_F_LINK_HI: mem_req_out.wdata = link[15:8];
                    `SMR_F_RSVD:   mem_req_out.wdata = `SMR_RSVD_VAL;
                    `SMR_F_STAT:   mem_req_out.wdata = sel_q ? `SMR_ST_D2H_INIT
                                                             : `SMR_ST_H2D_INIT;
                    `SMR_F_LEN:    mem_req_out.wdata = pay_q[7:0];
                    default:       mem_req_out.wdata = pay_q[15:8];
                endcase
            end
            SMR_XFER: begin
                if (k_q == 16'h0000) begin
                    mem_req_out.wdata = lmt[7:0];
                end else if (k_q == `SMR_F_LINK_HI) begin
                    mem_req_out.wdata = lmt[15:8];
                end else begin
                    mem_req_out.wdata = data_q[di];
                end
            end
            SMR_RET: begin
                // Reserved status bits are carried back as read
                if (k_q == `SMR_F_RSVD) begin
                    mem_req_out.wdata = st_q | ((op_q == SMR_OP_RECV) ? `SMR_ST_RETURN
                                                                       : `SMR_ST_GIVE);
                end else if (k_q == 16'h0000) begin
                    mem_req_out.wdata = pay_q[7:0];
                end else begin
                    mem_req_out.wdata = pay_q[15:8];
                end
            end
            default: mem_req_out.wdata = 8'h00;
        endcase
    end

    always_comb begin
        state_d = state_q;  op_d = op_q;  sel_d = sel_q;
        h2d_base_d = h2d_base_q;  d2h_base_d = d2h_base_q;  ntf_addr_d = ntf_addr_q;
        h2d_head_d = h2d_head_q;  d2h_head_d = d2h_head_q;
        pay_d = pay_q;  len_d = len_q;  ntf_val_d = ntf_val_q;  ntf_type_d = ntf_type_q;
        cur_d = cur_q;  k_d = k_q;  lnk_lo_d = lnk_lo_q;  cnt_d = cnt_q;  n_d = n_q;
        st_d = st_q;  empty_d = empty_q;  ovf_d = ovf_q;  done_d = done_q;  note_d = note_q;
        rdata_d = rdata_q;
        data_d = data_q;
        notify_out = 1'b0;
        if (rd_setup) begin
            unique case (paddr_in)
                `SMR_A_CMD:      rdata_d = {31'h0, state_q != SMR_IDLE};
                `SMR_A_STAT:     rdata_d = {27'h0, note_q, done_q, ovf_q, empty_q,
                                            state_q != SMR_IDLE};
                `SMR_A_H2D_BASE: rdata_d = h2d_base_q;
                `SMR_A_H2D_HEAD: rdata_d = {16'h0, h2d_head_q};
                `SMR_A_D2H_BASE: rdata_d = d2h_base_q;
                `SMR_A_D2H_HEAD: rdata_d = {16'h0, d2h_head_q};
                `SMR_A_GEOM:     rdata_d = {8'h0, cnt_q, pay_q};
                `SMR_A_LEN:      rdata_d = {16'h0, len_q};
                `SMR_A_NTF_TYPE: rdata_d = {29'h0, ntf_type_q};
                `SMR_A_NTF_VAL:  rdata_d = {16'h0, ntf_val_q};
                `SMR_A_NTF_ADDR: rdata_d = ntf_addr_q;
                default: begin
                    rdata_d = 32'h0;
                    if (in_data) begin
                        for (int b = 0; b < 4; b++) begin
                            rdata_d[8*b +: 8] = data_q[IW'({paddr_in[7:2], 2'b00}
                                                 - `SMR_A_DATA) + IW'(b)];
                        end
                    end
                end
            endcase
        end
        if (wr) begin
            unique case (paddr_in)
                `SMR_A_CMD: begin
                    if (state_q == SMR_IDLE) begin
                        k_d = 16'h0000;
                        n_d = 8'h00;
                        unique case (pwdata_in[2:0])
                            `SMR_CMD_INIT_H2D: begin
                                op_d = SMR_OP_INIT; sel_d = 1'b0; cur_d = h2d_head_q;
                                state_d = SMR_INIT;
                            end
                            `SMR_CMD_INIT_D2H: begin
                                op_d = SMR_OP_INIT; sel_d = 1'b1; cur_d = d2h_head_q;
                                state_d = SMR_INIT;
                            end
                            `SMR_CMD_SEND: begin
                                op_d = SMR_OP_SEND; sel_d = 1'b0; cur_d = h2d_head_q;
                                state_d = SMR_CHK; empty_d = 1'b0;
                            end
                            `SMR_CMD_RECV: begin
                                op_d = SMR_OP_RECV; sel_d = 1'b1; cur_d = d2h_head_q;
                                state_d = SMR_CHK; empty_d = 1'b0;
                            end
                            default: state_d = SMR_IDLE;
                        endcase
                    end
                end
                `SMR_A_STAT:     if (pwdata_in[`SMR_STAT_NOTE]) note_d = 1'b0;
                `SMR_A_H2D_BASE: h2d_base_d = pwdata_in;
                `SMR_A_H2D_HEAD: h2d_head_d = pwdata_in[15:0];
                `SMR_A_D2H_BASE: d2h_base_d = pwdata_in;
                `SMR_A_D2H_HEAD: d2h_head_d = pwdata_in[15:0];
                `SMR_A_GEOM:     {cnt_d, pay_d} = pwdata_in[23:0];
                `SMR_A_LEN:      len_d = pwdata_in[15:0];
                `SMR_A_NTF_TYPE: ntf_type_d = pwdata_in[2:0];
                `SMR_A_NTF_VAL:  ntf_val_d = pwdata_in[15:0];
                `SMR_A_NTF_ADDR: ntf_addr_d = pwdata_in;
                default: begin
                    if (in_data) begin
                        for (int b = 0; b < 4; b++) begin
                            data_d[IW'({paddr_in[7:2], 2'b00} - `SMR_A_DATA) + IW'(b)]
                                = pwdata_in[8*b +: 8];
                        end
                    end
                end
            endcase
        end
        // A notice in the clearing cycle still lands
        if (hit) note_d = 1'b1;
        unique case (state_q)
            SMR_IDLE: ;
            SMR_INIT: if (acc) begin
                k_d = k_q + 16'h0001;
                if (k_q == `SMR_F_LEN_HI) begin
                    k_d = 16'h0000;
                    n_d = n_q + 8'h01;
                    cur_d = link;
                    if ((n_q + 8'h01) >= cnt_q) state_d = SMR_IDLE;
                end
            end
            SMR_CHK: if (acc) begin
                st_d = mem_rsp_in.rdata;
                k_d = 16'h0000;
                // Device-owned buffers are never touched
                if (mem_rsp_in.rdata[`SMR_ST_OWN]) begin
                    empty_d = 1'b1;
                    state_d = SMR_IDLE;
                end else begin
                    done_d = mem_rsp_in.rdata[`SMR_ST_DONE];
                    ovf_d = mem_rsp_in.rdata[`SMR_ST_OVF];
                    state_d = SMR_LINK;
                end
            end
            SMR_LINK: if (acc) begin
                k_d = k_q + 16'h0001;
                lnk_lo_d = {8'h00, mem_rsp_in.rdata};
                if (k_q == `SMR_F_LINK_HI) begin
                    // The selected ring's header moves: the d2h head on a receive, the h2d head on a send
                    if (sel_q) d2h_head_d = {mem_rsp_in.rdata, lnk_lo_q[7:0]};
                    else       h2d_head_d = {mem_rsp_in.rdata, lnk_lo_q[7:0]};
                    k_d = 16'h0000;
                    state_d = SMR_XFER;
                end
            end
            SMR_XFER: if (acc) begin
                k_d = k_q + 16'h0001;
                if (op_q == SMR_OP_RECV) begin
                    if (k_q == 16'h0000) len_d[7:0] = mem_rsp_in.rdata;
                    else if (k_q == `SMR_F_LINK_HI) len_d[15:8] = mem_rsp_in.rdata;
                    else data_d[di] = mem_rsp_in.rdata;
                end
                if (last_xfer) begin
                    k_d = (op_q == SMR_OP_RECV) ? 16'h0000 : `SMR_F_RSVD;
                    state_d = SMR_RET;
                end
            end
            SMR_RET: if (acc) begin
                k_d = k_q + 16'h0001;
                if (k_q == `SMR_F_RSVD) state_d = SMR_NOTE;
            end
            SMR_NOTE: begin
                notify_out = 1'b1;
                state_d = SMR_IDLE;
            end
        endcase
    end

    assign pready_out  = psel_in & penable_in;
    assign pslverr_out = 1'b0;
    assign prdata_out  = rdata_q;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= SMR_IDLE;  op_q <= SMR_OP_INIT;  sel_q <= 1'b0;
            h2d_base_q <= 32'h0;  d2h_base_q <= 32'h0;  ntf_addr_q <= 32'h0;
            h2d_head_q <= 16'h0;  d2h_head_q <= 16'h0;
            pay_q <= `SMR_RST_PAY;  len_q <= 16'h0;  ntf_val_q <= 16'h0;
            ntf_type_q <= `SMR_NTF_NONE;
            cur_q <= 16'h0;  k_q <= 16'h0;  lnk_lo_q <= 16'h0;
            cnt_q <= `SMR_RST_CNT;  n_q <= 8'h0;  st_q <= 8'h0;
            empty_q <= 1'b0;  ovf_q <= 1'b0;  done_q <= 1'b0;  note_q <= 1'b0;
            rdata_q <= 32'h0;
            for (int i = 0; i < DATA_BYTES; i++) data_q[i] <= 8'h00;
        end else begin
            state_q <= state_d;  op_q <= op_d;  sel_q <= sel_d;
            h2d_base_q <= h2d_base_d;  d2h_base_q <= d2h_base_d;  ntf_addr_q <= ntf_addr_d;
            h2d_head_q <= h2d_head_d;  d2h_head_q <= d2h_head_d;
            pay_q <= pay_d;  len_q <= len_d;  ntf_val_q <= ntf_val_d;
            ntf_type_q <= ntf_type_d;
            cur_q <= cur_d;  k_q <= k_d;  lnk_lo_q <= lnk_lo_d;
            cnt_q <= cnt_d;  n_q <= n_d;  st_q <= st_d;
            empty_q <= empty_d;  ovf_q <= ovf_d;  done_q <= done_d;  note_q <= note_d;
            rdata_q <= rdata_d;
            data_q <= data_d;
        end
    end
endmodule

// >>> dv/smr_host_monitor.sv
`timescale 1ns/1ps
`include "smr_map.svh"
module smr_host_monitor (
    input wire logic                  clk_sys_in,
    input wire logic                  arst_n_in,
    input wire logic                  psel_in,
    input wire logic                  penable_in,
    input wire logic                  pwrite_in,
    input wire logic [7:0]            paddr_in,
    input wire logic [31:0]           pwdata_in,
    input wire logic [31:0]           prdata_out,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out,
    input wire smr_pkg::smr_mem_req_s mem_req_out,
    input wire smr_pkg::smr_mem_rsp_s mem_rsp_in,
    input wire smr_pkg::smr_bus_wr_s  snoop_in,
    input wire smr_pkg::smr_vec_irq_s vec_irq_in,
    input wire logic                  notify_out
);
    import smr_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    logic give_w;
    assign give_w = mem_req_out.valid && mem_req_out.we && mem_rsp_in.ready
        && mem_req_out.wdata[`SMR_ST_OWN];
    sequence s_wait;
        mem_req_out.valid && !mem_rsp_in.ready;
    endsequence
    sequence s_move;
        psel_in && penable_in && pwrite_in && paddr_in == `SMR_A_CMD
            && (pwdata_in[2:0] == `SMR_CMD_SEND || pwdata_in[2:0] == `SMR_CMD_RECV);
    endsequence
    sequence s_look;
        mem_req_out.valid && !mem_req_out.we;
    endsequence
    ready_follow_a: assert property (pready_out == (psel_in && penable_in))
        else $error("pready does not follow the access phase");
    no_error_a: assert property (!pslverr_out) else $error("slave error raised");
    req_hold_a: assert property (s_wait |=> mem_req_out.valid && $stable(mem_req_out))
        else $error("memory request changed before ready");
    note_cause_a: assert property (notify_out |-> $past(give_w))
        else $error("notify without a preceding ownership hand-over");
    note_idle_a: assert property (notify_out |-> !mem_req_out.valid)
        else $error("memory access still running at notify");
    note_gap_a: assert property (notify_out |=> !notify_out [*3])
        else $error("notify longer than one cycle or repeated");
    cmd_look_a: assert property (s_move |-> ##[1:4] s_look)
        else $error("transfer did not begin by reading the buffer");
    unmapped_rd_a: assert property (psel_in && penable_in && !pwrite_in
        && paddr_in == 8'hFC |-> prdata_out == 32'h0)
        else $error("unmapped read returned nonzero");
endmodule
bind smr_host smr_host_monitor i_smr_host_monitor (
    .clk_sys_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .mem_req_out, .mem_rsp_in, .snoop_in,
    .vec_irq_in, .notify_out
);

// >>> dv/smr_dev.sv
`timescale 1ns/1ps
`include "smr_map.svh"
module smr_dev (
    input  wire logic                  clk_sys_in,
    input  wire logic                  arst_n_in,
    input  wire smr_pkg::smr_mem_req_s mem_req_in,
    output smr_pkg::smr_mem_rsp_s      mem_rsp_out,
    output smr_pkg::smr_bus_wr_s       snoop_out,
    output smr_pkg::smr_vec_irq_s      vec_irq_out,
    input  wire logic                  notify_in
);
    import smr_pkg::*;
    logic [7:0]  mem [0:65535];
    logic [15:0] h2d_hd = 16'h0;
    logic [15:0] d2h_hd = 16'h0;
    logic [2:0]  ntf = 3'h0;
    logic [15:0] ntf_val = 16'h0;
    logic [31:0] ntf_addr = 32'h0;
    logic [7:0]  rx [$];
    int          lat = 0;
    int          wait_cnt = 0;
    int          bad_am = 0;
    initial begin
        snoop_out = '0;
        vec_irq_out = '0;
    end
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mem_rsp_out <= '0;
            wait_cnt <= 0;
        end else begin
            // Released data line keeps moving so a stale byte cannot pass
            mem_rsp_out <= {1'b0, ~mem_rsp_out.rdata};
            wait_cnt <= 0;
            if (mem_req_in.valid && mem_rsp_out.ready) begin
                if (mem_req_in.we) mem[mem_req_in.addr[15:0]] <= mem_req_in.wdata;
                if (mem_req_in.am !== 6'h3D) bad_am <= bad_am + 1;
            end else if (mem_req_in.valid && wait_cnt >= lat) begin
                mem_rsp_out <= {1'b1, mem[mem_req_in.addr[15:0]]};
            end else if (mem_req_in.valid) begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
    task automatic notice();
        @(posedge clk_sys_in);
        if (ntf == `SMR_NTF_MMAP) snoop_out <= {1'b1, ntf_addr[29:0], ntf_val};
        if (ntf == `SMR_NTF_VECT) vec_irq_out <= {1'b1, ntf_addr[31:16]};
        @(posedge clk_sys_in);
        snoop_out <= {1'b0, ~snoop_out[45:0]};
        vec_irq_out <= {1'b0, ~vec_irq_out[15:0]};
    endtask
    // Consume every owned buffer in turn; stop at the first host-owned one
    task automatic take();
        logic [15:0] o;
        o = 16'h4000 + h2d_hd;
        while (mem[o+16'h3][`SMR_ST_OWN] === 1'b1) begin
            h2d_hd = {mem[o+16'h1], mem[o]};
            for (int i = 0; i < {mem[o+16'h5], mem[o+16'h4]}; i++)
                rx.push_back(mem[o+16'h6+16'(i)]);
            mem[o+16'h3] = mem[o+16'h3] & 8'hFC;
            notice();
            o = 16'h4000 + h2d_hd;
        end
    endtask
    always @(posedge clk_sys_in) if (notify_in === 1'b1) take();
    task automatic give(input int len, input logic [7:0] seed);
        logic [15:0] o;
        logic [15:0] room;
        int          k;
        o = 16'h8000 + d2h_hd;
        room = {mem[o+16'h5], mem[o+16'h4]};
        k = (len > room) ? room : len;
        if (mem[o+16'h3][`SMR_ST_OWN] !== 1'b1) return;
        d2h_hd = {mem[o+16'h1], mem[o]};
        for (int i = 0; i < k; i++) mem[o+16'h6+16'(i)] = seed + 8'(i);
        {mem[o+16'h5], mem[o+16'h4]} = 16'(k);
        mem[o+16'h3] = (mem[o+16'h3] & 8'hF8) | ((len > room) ? 8'h04 : 8'h00);
        notice();
    endtask
endmodule

// >>> dv/tb_smr_host.sv
`timescale 1ns/1ps
`include "smr_map.svh"
module tb_smr_host;
    import smr_pkg::*;
    logic         clk_sys_in = 1'b0;
    logic         arst_n_in = 1'b0;
    logic         psel_in = 1'b0;
    logic         penable_in = 1'b0;
    logic         pwrite_in = 1'b0;
    logic [7:0]   paddr_in = 8'h00;
    logic [31:0]  pwdata_in = 32'h0;
    logic [31:0]  prdata_out;
    logic         pready_out;
    logic         pslverr_out;
    smr_mem_req_s mem_req;
    smr_mem_rsp_s mem_rsp;
    smr_bus_wr_s  snoop;
    smr_vec_irq_s vec_irq;
    logic         notify;
    int           fails = 0;
    int           check_count = 0;
    logic [2:0]   tys [6] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h5, 3'h4};
    smr_host i_smr_host (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .mem_req_out(mem_req), .mem_rsp_in(mem_rsp),
        .snoop_in(snoop), .vec_irq_in(vec_irq), .notify_out(notify));
    smr_dev i_smr_dev (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .mem_req_in(mem_req),
        .mem_rsp_out(mem_rsp), .snoop_out(snoop), .vec_irq_out(vec_irq), .notify_in(notify));
    always #50 clk_sys_in = ~clk_sys_in;
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] q);
        check_count++;
        if (q !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, q);
        end
    endtask
    // Request held until pready is sampled high; one idle edge between transfers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do @(posedge clk_sys_in); while (pready_out !== 1'b1);
        q = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        cmp($sformatf("register %h", a), e, q & m);
    endtask
    task automatic run(input logic [2:0] c);
        logic [31:0] q;
        wr(`SMR_A_CMD, {29'h0, c});
        // Lands while busy and must be ignored, or the h2d ring gets rebuilt
        wr(`SMR_A_CMD, {29'h0, `SMR_CMD_INIT_H2D});
        do apb(1'b0, `SMR_A_STAT, 32'h0, q); while (q[0] !== 1'b0);
    endtask
    function automatic logic [31:0] m16(input logic [15:0] i);
        return {16'h0, i_smr_dev.mem[i+16'h1], i_smr_dev.mem[i]};
    endfunction
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end
    initial begin
        int len;
        int k;
        repeat (5) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        chk(`SMR_A_GEOM, 32'hFFFFFFFF, {8'h0, `SMR_RST_CNT, `SMR_RST_PAY});
        chk(`SMR_A_NTF_TYPE, 32'hFFFFFFFF, 32'h0);
        chk(8'hFC, 32'hFFFFFFFF, 32'h0);
        wr(`SMR_A_H2D_BASE, 32'h3D004000);
        wr(`SMR_A_H2D_HEAD, 32'h10);
        wr(`SMR_A_D2H_BASE, 32'h3D008000);
        wr(`SMR_A_D2H_HEAD, 32'h40);
        wr(`SMR_A_GEOM, 32'h00020010);
        run(`SMR_CMD_INIT_H2D);
        run(`SMR_CMD_INIT_D2H);
        for (int b = 0; b < 2; b++) begin
            cmp("h2d link", b ? 32'h10 : 32'h26, m16(16'h4010 + 16'(22*b)));
            cmp("h2d status", 32'h0200, m16(16'h4012 + 16'(22*b)));
            cmp("d2h link", b ? 32'h40 : 32'h56, m16(16'h8040 + 16'(22*b)));
            cmp("d2h status", 32'h0300, m16(16'h8042 + 16'(22*b)));
            cmp("d2h length", 32'h10, m16(16'h8044 + 16'(22*b)));
        end
        i_smr_dev.h2d_hd = 16'h10;
        i_smr_dev.d2h_hd = 16'h40;
        i_smr_dev.ntf_val = 16'h0040;
        i_smr_dev.ntf_addr = 32'h3D0E2044;
        wr(`SMR_A_NTF_VAL, 32'h40);
        wr(`SMR_A_NTF_ADDR, 32'h3D0E2044);
        // Device keeps notifying while the host selects codes 0 to 5 in turn
        for (int i = 0; i < 6; i++) begin
            len = (i == 5) ? 20 : i + 3;
            k = (len > 16) ? 16 : len;
            i_smr_dev.ntf = (tys[i] == `SMR_NTF_VECT) ? `SMR_NTF_VECT : `SMR_NTF_MMAP;
            i_smr_dev.lat = i % 3;
            wr(`SMR_A_NTF_TYPE, {29'h0, tys[i]});
            wr(`SMR_A_LEN, 32'(len));
            for (int w = 0; w < 4; w++)
                wr(8'(`SMR_A_DATA + 4*w), {4{8'(16*i+4*w)}} + 32'h03020100);
            run(`SMR_CMD_SEND);
            repeat (12) @(posedge clk_sys_in);
            cmp("sent bytes", 32'(k), 32'(i_smr_dev.rx.size()));
            for (int j = 0; j < k; j++)
                cmp("payload", 32'(8'(16*i+j)), 32'(i_smr_dev.rx.pop_front()));
            cmp("device header", (i % 2) ? 32'h10 : 32'h26, 32'(i_smr_dev.h2d_hd));
            chk(`SMR_A_H2D_HEAD, 32'hFFFF, (i % 2) ? 32'h10 : 32'h26);
            chk(`SMR_A_STAT, 32'h10, 32'(tys[i] inside {3'h2, 3'h4}) << 4);
            wr(`SMR_A_STAT, 32'h8);
        end
        run(`SMR_CMD_RECV);
        chk(`SMR_A_STAT, 32'h2, 32'h2);
        i_smr_dev.ntf = `SMR_NTF_MMAP;
        wr(`SMR_A_NTF_TYPE, 32'h2);
        i_smr_dev.give(20, 8'h80);
        chk(`SMR_A_STAT, 32'h10, 32'h10);
        run(`SMR_CMD_RECV);
        chk(`SMR_A_LEN, 32'hFFFF, 32'h10);
        chk(`SMR_A_STAT, 32'h4, 32'h4);
        for (int w = 0; w < 4; w++)
            chk(8'(`SMR_A_DATA + 4*w), 32'hFFFFFFFF, {4{8'(128+4*w)}} + 32'h03020100);
        cmp("returned length", 32'h10, m16(16'h8044));
        cmp("returned status", 32'h07, 32'(i_smr_dev.mem[16'h8043]));
        i_smr_dev.give(3, 8'h10);
        run(`SMR_CMD_RECV);
        chk(`SMR_A_LEN, 32'hFFFF, 32'h3);
        chk(`SMR_A_STAT, 32'h4, 32'h0);
        chk(`SMR_A_DATA, 32'h00FFFFFF, 32'h00121110);
        cmp("device d2h header", 32'h40, 32'(i_smr_dev.d2h_hd));
        cmp("bus modifier faults", 32'h0, 32'(i_smr_dev.bad_am));
        report_and_stop();
    end
endmodule
